// ==== src/stc_pkg.sv ====
// Contract
// - Counter is 16 bits in readable, writable high and low byte registers.
// - Wrap from all ones to zero sets the overflow interrupt flag.
// - Control bit 0 starts counting when set, halts it when clear.
// - Control bit 7 selects one 16-bit access or two 8-bit accesses.
// - Control bit 6 is read-only, set while timer oscillator clocks system.
// - Bits 5:4 prescale input clock: 11 by 8, 10 by 4, 01 by 2, 00 none.
// - Control bit 3 enables timer oscillator; clear shuts it off for power.
// - Bit 2 skips synchronising external input; ignored with internal source.
// - Bit 1 counts external rising edges when set, else internal clock/4.
// - After oscillator failure the status bit shows the actual clock source.
package stc_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] STC_OFS_CTRL = 8'h00;
   localparam logic [7:0] STC_OFS_LOW = 8'h04;
   localparam logic [7:0] STC_OFS_HIGH = 8'h08;
   localparam logic [7:0] STC_OFS_STAT = 8'h0C;
   localparam logic [7:0] STC_OFS_MASK = 8'h10;
   // ****************************************
   // Control fields and reset values
   // ****************************************
   localparam int STC_B_ON = 0;
   localparam int STC_B_SRC = 1;
   localparam int STC_B_NOSYNC = 2;
   localparam int STC_B_OSCEN = 3;
   localparam int STC_B_PS_LO = 4;
   localparam int STC_B_RUN = 6;
   localparam int STC_B_WIDE = 7;
   localparam logic [7:0] STC_CTRL_RST = 8'h00;
   localparam logic [7:0] STC_CTRL_WMASK = 8'hBF;
   localparam logic [15:0] STC_CNT_RST = 16'h0000;
   localparam logic [1:0] STC_QDIV_LAST = 2'h3;
   localparam logic [1:0] STC_RESP_OKAY = 2'h0;
   localparam logic [1:0] STC_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0]
   {
      STC_WR_IDLE = 3'b001,
      STC_WR_ACT = 3'b010,
      STC_WR_RESP = 3'b100
   } stc_wr_st_t;
endpackage : stc_pkg

// ==== src/stc_timer.sv ====
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module stc_timer
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins and clock system
   input wire logic external_clock_input,
   input wire logic sys_clk_from_timer_osc,
   output logic timer_osc_enable,
   output logic irq
);
   import stc_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed
   {
      stc_wr_st_t wst;
      logic [7:0] awaddr;
      logic aw_got;
      logic [31:0] wdata;
      logic w_got;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] ctrl;
      logic [15:0] cnt;
      logic [7:0] hi_buf;
      logic ovf;
      logic ovf_mask;
      logic [1:0] qdiv;
      logic [2:0] pre;
      logic [1:0] ext_sync;
      logic run_s1;
      logic run_s2;
      logic ext_prev;
      logic ext_pend;
      logic awready;
      logic wready;
      logic arready;
      logic irq;
   } stc_state_t;

   stc_state_t s_q;
   stc_state_t s_d;

   // True on the input tick that completes the selected prescale ratio.
   // The limit is the ratio minus one, so a ratio of 1:1 passes every tick.
   function automatic logic prescale_done(input logic [2:0] pre,
                                          input logic [1:0] ps);
      logic [2:0] lim;
      lim = 3'h0;
      unique case (ps)
         2'h0: lim = 3'h0;
         2'h1: lim = 3'h1;
         2'h2: lim = 3'h3;
         2'h3: lim = 3'h7;
      endcase
      return pre >= lim;
   endfunction : prescale_done

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      logic tick;
      logic raw_edge;
      logic ext_lvl;
      logic do_wr;
      logic wr_err;
      logic [7:0] ctrl_w;
      logic [7:0] wb;
      logic [15:0] cnt_n;
      logic wrap;
      logic edge_seen;
      tick = 1'b0;
      raw_edge = 1'b0;
      ext_lvl = 1'b0;
      do_wr = 1'b0;
      wr_err = 1'b0;
      ctrl_w = 8'h00;
      wb = 8'h00;
      cnt_n = 16'h0000;
      wrap = 1'b0;
      edge_seen = 1'b0;
      s_d = s_q;

      // Pins pass two flip-flops before any use.
      s_d.ext_sync = {s_q.ext_sync[0], external_clock_input};
      s_d.run_s1 = sys_clk_from_timer_osc;
      s_d.run_s2 = s_q.run_s1;
      // The synchronised clock status lands in the read-only bit.
      s_d.ctrl[STC_B_RUN] = s_q.run_s2;

      // Instruction rate is the bus clock over four.
      s_d.qdiv = s_q.qdiv + 2'h1;
      // The unsynchronised option still samples through the pin stage:
      // this fabric has one clock, so only the extra edge stage is skipped.
      ext_lvl = s_q.ext_sync[1];
      s_d.ext_prev = ext_lvl;
      raw_edge = ext_lvl & ~s_q.ext_prev;
      // In synchronised mode an edge waits for the next instruction
      // phase instead of being dropped; a second edge inside the same
      // phase merges with the first, which caps the external rate.
      edge_seen = raw_edge | s_q.ext_pend;
      s_d.ext_pend = 1'b0;
      if (s_q.ctrl[STC_B_SRC])
      begin
         if (s_q.ctrl[STC_B_NOSYNC])
         begin
            tick = raw_edge;
         end
         else
         begin
            tick = edge_seen & (s_q.qdiv == STC_QDIV_LAST);
            s_d.ext_pend = edge_seen & (s_q.qdiv != STC_QDIV_LAST);
         end
      end
      else
      begin
         tick = (s_q.qdiv == STC_QDIV_LAST);
      end

      cnt_n = s_q.cnt;
      if (s_q.ctrl[STC_B_ON] && tick)
      begin
         if (prescale_done(s_q.pre,
                           s_q.ctrl[STC_B_PS_LO+1:STC_B_PS_LO]))
         begin
            s_d.pre = 3'h0;
            cnt_n = s_q.cnt + 16'h0001;
            if (s_q.cnt == 16'hFFFF)
            begin
               wrap = 1'b1;
               s_d.ovf = 1'b1;
            end
         end
         else
         begin
            s_d.pre = s_q.pre + 3'h1;
         end
      end

      // ****************************************
      // Write channel
      // ****************************************
      unique case (s_q.wst)
         STC_WR_IDLE:
         begin
            if (s_axi_awvalid)
            begin
               s_d.awaddr = s_axi_awaddr;
               s_d.aw_got = 1'b1;
            end
            if (s_axi_wvalid)
            begin
               s_d.wdata = s_axi_wdata;
               s_d.w_got = 1'b1;
            end
            if (s_axi_awvalid || s_axi_wvalid)
            begin
               s_d.wst = STC_WR_ACT;
            end
         end
         STC_WR_ACT:
         begin
            if (!s_q.aw_got && s_axi_awvalid)
            begin
               s_d.awaddr = s_axi_awaddr;
               s_d.aw_got = 1'b1;
            end
            if (!s_q.w_got && s_axi_wvalid)
            begin
               s_d.wdata = s_axi_wdata;
               s_d.w_got = 1'b1;
            end
            if (s_q.aw_got && s_q.w_got)
            begin
               do_wr = 1'b1;
               s_d.aw_got = 1'b0;
               s_d.w_got = 1'b0;
               s_d.wst = STC_WR_RESP;
            end
         end
         STC_WR_RESP:
         begin
            if (s_axi_bready)
            begin
               s_d.wst = STC_WR_IDLE;
            end
         end
      endcase

      wb = s_q.wdata[7:0];
      if (do_wr)
      begin
         unique case (s_q.awaddr)
            STC_OFS_CTRL:
            begin
               ctrl_w = (wb & STC_CTRL_WMASK)
                        | (s_d.ctrl & ~STC_CTRL_WMASK);
               s_d.ctrl = ctrl_w;
            end
            STC_OFS_LOW:
            begin
               if (s_q.ctrl[STC_B_WIDE])
               begin
                  cnt_n = {s_q.hi_buf, wb};
               end
               else
               begin
                  cnt_n = {cnt_n[15:8], wb};
               end
               s_d.pre = 3'h0;
            end
            STC_OFS_HIGH:
            begin
               if (s_q.ctrl[STC_B_WIDE])
               begin
                  s_d.hi_buf = wb;
               end
               else
               begin
                  cnt_n = {wb, cnt_n[7:0]};
               end
            end
            STC_OFS_STAT:
            begin
               // A wrap in this same cycle keeps the flag set.
               if (wb[0] && !wrap)
               begin
                  s_d.ovf = 1'b0;
               end
            end
            STC_OFS_MASK: s_d.ovf_mask = wb[0];
            // Unmapped offsets answer with an error and change nothing.
            default: wr_err = 1'b1;
         endcase
         s_d.bresp = wr_err ? STC_RESP_SLVERR : STC_RESP_OKAY;
      end
      s_d.cnt = cnt_n;

      // ****************************************
      // Read channel
      // ****************************************
      if (s_q.rvalid && s_axi_rready)
      begin
         s_d.rvalid = 1'b0;
      end
      if (!s_q.rvalid && s_axi_arvalid)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp = STC_RESP_OKAY;
         s_d.rdata = 32'h00000000;
         unique case (s_axi_araddr)
            STC_OFS_CTRL: s_d.rdata[7:0] = s_q.ctrl;
            STC_OFS_LOW:
            begin
               // A low read in wide mode freezes the high byte for the
               // next high read, so a carry between the reads is not seen.
               s_d.rdata[7:0] = s_q.cnt[7:0];
               if (s_q.ctrl[STC_B_WIDE])
               begin
                  s_d.hi_buf = s_q.cnt[15:8];
               end
            end
            STC_OFS_HIGH:
               s_d.rdata[7:0] = s_q.ctrl[STC_B_WIDE]
                                ? s_q.hi_buf : s_q.cnt[15:8];
            STC_OFS_STAT: s_d.rdata[0] = s_q.ovf;
            STC_OFS_MASK: s_d.rdata[0] = s_q.ovf_mask;
            default: s_d.rresp = STC_RESP_SLVERR;
         endcase
      end

      s_d.irq = s_d.ovf & s_d.ovf_mask;

      // Readies are registered from the state that the next edge loads,
      // so no output is decoded from state after the flops.
      s_d.awready = (s_d.wst == STC_WR_IDLE)
                    || ((s_d.wst == STC_WR_ACT) && !s_d.aw_got);
      s_d.wready = (s_d.wst == STC_WR_IDLE)
                   || ((s_d.wst == STC_WR_ACT) && !s_d.w_got);
      s_d.arready = !s_d.rvalid;
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_q <= '0;
         s_q.wst <= STC_WR_IDLE;
         s_q.ctrl <= STC_CTRL_RST;
         s_q.cnt <= STC_CNT_RST;
         s_q.awready <= 1'b1;
         s_q.wready <= 1'b1;
         s_q.arready <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Every output is taken straight from a bit of the state record.
   assign s_axi_awready = s_q.awready;
   assign s_axi_wready = s_q.wready;
   assign s_axi_bvalid = s_q.wst[2];
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign timer_osc_enable = s_q.ctrl[STC_B_OSCEN];
   assign irq = s_q.irq;
endmodule : stc_timer

// ==== testbench/stc_timer_checker.sv ====
`timescale 1ns/1ns
module stc_timer_checker
(
   // Bus side
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Timer side
   input wire logic timer_osc_enable,
   input wire logic irq
);
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rlat: assert property (p_rlat) else $error("read late");
   property p_rhi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
   endproperty
   a_rhi: assert property (p_rhi) else $error("rdata high");
   property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_busy: assert property (p_busy) else $error("ready busy");
   property p_brel; s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid && s_axi_awready && s_axi_wready;
   endproperty
   a_brel: assert property (p_brel) else $error("b release");
   property p_osc; $changed(timer_osc_enable) |-> s_axi_bvalid;
   endproperty
   a_osc: assert property (p_osc) else $error("osc moved");
   property p_irqf; $fell(irq) |-> s_axi_bvalid;
   endproperty
   a_irqf: assert property (p_irqf) else $error("irq fell");
   property p_arb; s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_arb: assert property (p_arb) else $error("ar busy");
   property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_rdone: assert property (p_rdone) else $error("r stuck");
endmodule : stc_timer_checker

// ==== testbench/stc_clk_src.sv ====
`timescale 1ns/1ns
module stc_clk_src
(
   // Clock
   input wire logic aclk,
   // Pins
   output logic external_clock_input,
   output logic sys_clk_from_timer_osc
);
   initial
   begin
      external_clock_input = 1'b0;
      sys_clk_from_timer_osc = 1'b0;
   end
   // Slow pulses so that even the synchronised path sees each one.
   task automatic pulses(input int n);
      repeat (n)
      begin
         repeat (10) @(posedge aclk);
         external_clock_input <= 1'b1;
         repeat (10) @(posedge aclk);
         external_clock_input <= 1'b0;
      end
      repeat (10) @(posedge aclk);
   endtask : pulses
   task automatic on_sys(input logic v);
      sys_clk_from_timer_osc <= v;
      repeat (4) @(posedge aclk);
   endtask : on_sys
endmodule : stc_clk_src

// ==== testbench/test_stc_timer.sv ====
`timescale 1ns/1ns
module test_stc_timer;
   import stc_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, timer_osc_enable, irq;
   logic external_clock_input, sys_clk_from_timer_osc;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int err_count = 0, checks_done = 0;
   stc_timer dut
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .external_clock_input(external_clock_input),
      .sys_clk_from_timer_osc(sys_clk_from_timer_osc),
      .timer_osc_enable(timer_osc_enable),
      .irq(irq)
   );
   stc_clk_src src
   (
      .aclk(aclk),
      .external_clock_input(external_clock_input),
      .sys_clk_from_timer_osc(sys_clk_from_timer_osc)
   );
   always #20 aclk = ~aclk;
   // ****************************************
   // Bus tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // Ready is sampled at the falling edge, where it has settled.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ta, tw, da, dw;
      da = 1'b0;
      dw = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
         @(negedge aclk);
         ta = s_axi_awready;
         tw = s_axi_wready;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         da = da | ta;
         dw = dw | tw;
      end while (!(da && dw));
      do
      begin
         @(negedge aclk);
         ta = s_axi_bvalid;
         @(posedge aclk);
      end while (!ta);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      logic t;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(negedge aclk);
         t = s_axi_arready;
         @(posedge aclk);
      end while (!t);
      s_axi_arvalid <= 1'b0;
      do
      begin
         @(negedge aclk);
         t = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
      end while (!t);
   endtask : rd
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(d, e);
   endtask : rchk
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_ctrl();
      rchk(STC_OFS_CTRL, 32'h0);
      chk({31'h0, timer_osc_enable}, 32'h0);
      wr(STC_OFS_CTRL, 8'hC8);
      chk({31'h0, timer_osc_enable}, 32'h1);
      rchk(STC_OFS_CTRL, 32'h88);
      src.on_sys(1'b1);
      rchk(STC_OFS_CTRL, 32'hC8);
      src.on_sys(1'b0);
      wr(STC_OFS_CTRL, 8'h00);
      chk({31'h0, timer_osc_enable}, 32'h0);
   endtask : t_ctrl
   task automatic t_bytes();
      logic [31:0] d;
      logic [1:0] r;
      wr(STC_OFS_HIGH, 8'h12);
      wr(STC_OFS_LOW, 8'h34);
      chk({30'h0, s_axi_bresp}, {30'h0, STC_RESP_OKAY});
      rchk(STC_OFS_HIGH, 32'h12);
      rchk(STC_OFS_LOW, 32'h34);
      rd(8'h14, d, r);
      chk({30'h0, r}, {30'h0, STC_RESP_SLVERR});
      chk(d, 32'h0);
      wr(8'h14, 8'h55);
      chk({30'h0, s_axi_bresp}, {30'h0, STC_RESP_SLVERR});
      wr(STC_OFS_CTRL, 8'h80);
      wr(STC_OFS_HIGH, 8'hAB);
      wr(STC_OFS_CTRL, 8'h00);
      rchk(STC_OFS_HIGH, 32'h12);
      wr(STC_OFS_CTRL, 8'h80);
      wr(STC_OFS_LOW, 8'hCD);
      wr(STC_OFS_CTRL, 8'h00);
      rchk(STC_OFS_HIGH, 32'hAB);
   endtask : t_bytes
   task automatic t_ovf();
      logic [31:0] d;
      logic [1:0] r;
      wr(STC_OFS_CTRL, 8'h80);
      wr(STC_OFS_HIGH, 8'hFF);
      wr(STC_OFS_LOW, 8'hFE);
      wr(STC_OFS_CTRL, 8'h81);
      repeat (12) @(posedge aclk);
      wr(STC_OFS_CTRL, 8'h80);
      rchk(STC_OFS_STAT, 32'h1);
      chk({31'h0, irq}, 32'h0);
      rd(STC_OFS_LOW, d, r);
      rchk(STC_OFS_HIGH, 32'h0);
      repeat (20) @(posedge aclk);
      rchk(STC_OFS_LOW, d);
      wr(STC_OFS_MASK, 8'h01);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h1);
      wr(STC_OFS_STAT, 8'h01);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h0);
      rchk(STC_OFS_STAT, 32'h0);
   endtask : t_ovf
   task automatic t_ext();
      logic [7:0] cf [5] = '{8'h87, 8'h97, 8'hA7, 8'hB7, 8'h83};
      logic [7:0] ex [5] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h08};
      for (int i = 0; i < 5; i++)
      begin
         wr(STC_OFS_CTRL, cf[i]);
         wr(STC_OFS_HIGH, 8'h00);
         wr(STC_OFS_LOW, 8'h00);
         src.pulses(8);
         rchk(STC_OFS_LOW, {24'h0, ex[i]});
      end
   endtask : t_ext
   task automatic complete_run();
      if (err_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_ctrl();
      t_bytes();
      t_ovf();
      t_ext();
      complete_run();
   end
   initial
   begin
      repeat (20000) @(posedge aclk);
      err_count++;
      complete_run();
   end
endmodule : test_stc_timer
bind stc_timer stc_timer_checker chk_i
(
   .aclk(aclk),
   .aresetn(aresetn),
   .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .timer_osc_enable(timer_osc_enable),
   .irq(irq)
);
